// ===== verilog/fss_supervisor.sv
// Fault reporting, safe-state and gate-drive supervision with APB registers.
// Assumes synchronous comparator inputs and a combinational pin return path.
`timescale 1ns/10ps
`include "fss_map.svh"
module fss_supervisor #(
  parameter int PG_PULSE_CYCLES = `FSS_PG_PULSE_NS / `FSS_CLK_NS
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Enables
  input wire logic logic_enable_in,
  input wire logic ignition_enable_in,
  output logic regulators_enable,
  // Comparators and monitors
  input wire fss_pkg::fss_rail_t rail_uv,
  input wire fss_pkg::fss_rail_t rail_ov,
  input wire logic overtemp_shutdown,
  input wire logic regulation_reference_uv,
  input wire logic monitor_reference_uv,
  input wire logic monitor_reference_fail,
  input wire logic wd_fault_event,
  // Self-test stimulus
  output logic uv_test_force,
  output logic ov_test_force,
  output logic ot_test_force,
  // Open-drain fault pins
  input wire logic power_good_n_in,
  output logic power_good_n_out,
  output logic power_good_n_oe,
  input wire logic watchdog_fault_n_in,
  output logic watchdog_fault_n_out,
  output logic watchdog_fault_n_oe,
  input wire logic general_fault_n_in,
  output logic general_fault_n_out,
  output logic general_fault_n_oe,
  // Safe-state pin
  output logic safe_state_out,
  input wire logic safe_state_sense,
  // Gate drives
  output logic battery_disconnect_drive,
  output logic phase_a_isolator_drive,
  output logic phase_b_isolator_drive,
  output logic phase_c_isolator_drive
);
  import fss_pkg::*;

  // ****************************************
  // Declarations
  // ****************************************
  fss_test_if tif ();
  logic [3:0] gate; // Software gate requests
  logic [4:0] cfg; // Option bits
  logic [13:0] fault; // Sticky non-watchdog faults
  logic [13:0] flt_ev; // Fault events this cycle
  logic wd_lat; // Latched watchdog fault
  logic mon_ok; // Diagnostics trustworthy
  fss_rail_t diag_uv; // Reported undervoltage
  fss_rail_t diag_ov; // Reported overvoltage
  logic mcu_bad;
  logic g5v_bad;
  logic mismatch;
  logic pulse_trig;
  logic pulse_active;
  logic any_flt;
  logic kill_all;
  logic [3:0] drive; // Gate drive levels
  logic [4:0] sel; // Register select
  logic wr_en;
  logic [31:0] rd_mux;
  logic [31:0] status;

  // ****************************************
  // Address decode
  // ****************************************
  // One-hot select, shared by read and write paths
  function automatic logic [4:0] reg_sel(input logic [7:0] a);
    reg_sel = {a == `FSS_FAULT_OFS, a == `FSS_VERIFY_OFS, a == `FSS_CONFIG_OFS,
      a == `FSS_GATE_OFS, a == `FSS_STATUS_OFS};
  endfunction
  assign sel = reg_sel(paddr);
  // Write lands on the completing edge only
  assign wr_en = psel & penable & pready & pwrite;

  // ****************************************
  // APB answer path
  // ****************************************
  // One wait state: ready in the second access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (psel && penable && !pready) begin
      pready <= 1'b1;
      prdata <= pwrite ? 32'h0000_0000 : rd_mux;
      pslverr <= ~|sel; // Unmapped address errors
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // Status word, pin levels read back from the pads
  always_comb begin
    status = 32'h0000_0000;
    status[`FSS_ST_SSOK] = ~fault[`FSS_FLT_MISMATCH];
    status[`FSS_ST_WDF] = wd_lat;
    status[`FSS_ST_DONE] = tif.done;
    status[`FSS_ST_VFAIL] = tif.done & (|tif.verify);
    status[4] = power_good_n_in;
    status[5] = watchdog_fault_n_in;
    status[6] = general_fault_n_in;
    status[7] = safe_state_sense;
    status[8] = regulators_enable;
  end

  // Read mux, unmapped reads as zero
  always_comb begin
    case (sel)
      5'h01: rd_mux = status;
      5'h02: rd_mux = {28'h0000000, gate};
      5'h04: rd_mux = {27'h0000000, cfg};
      5'h08: rd_mux = {21'h000000, tif.verify};
      5'h10: rd_mux = {18'h00000, fault};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // ****************************************
  // Software registers
  // ****************************************
  // Gate requests, all four bits replaced together by each write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gate <= `FSS_GATE_RST;
    end else if (wr_en && sel[1]) begin
      gate <= pwdata[3:0];
    end
  end

  // Option bits
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg <= `FSS_CONFIG_RST;
    end else if (wr_en && sel[2]) begin
      cfg <= pwdata[4:0];
    end
  end

  // ****************************************
  // Enables and self-test
  // ****************************************
  // Supply follows the OR of both enables
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      regulators_enable <= 1'b0;
    end else begin
      regulators_enable <= logic_enable_in | ignition_enable_in;
    end
  end

  assign tif.run = regulators_enable;
  assign tif.uv_cmp = rail_uv;
  assign tif.ov_cmp = rail_ov;
  assign tif.ot_cmp = overtemp_shutdown;
  assign uv_test_force = tif.force_uv;
  assign ov_test_force = tif.force_ov;
  assign ot_test_force = tif.force_ot;

  fss_selftest u_selftest (
    .pclk(pclk),
    .presetn(presetn),
    .tif(tif)
  );

  // ****************************************
  // Fault detection
  // ****************************************
  // Comparators only count once tests are over and stimuli gone
  assign mon_ok = tif.done & ~tif.testing;
  // A dead monitor reference shows every rail as bad
  assign diag_uv = mon_ok ? (rail_uv | {5{monitor_reference_fail}}) : 5'h00;
  assign diag_ov = mon_ok ? rail_ov : 5'h00;
  assign mcu_bad = diag_uv[`FSS_RAIL_MCU] | diag_ov[`FSS_RAIL_MCU];
  assign g5v_bad = diag_uv[`FSS_RAIL_G5V] | diag_ov[`FSS_RAIL_G5V];
  // Pin compared with its own flop; pad loop is assumed same-cycle
  assign mismatch = tif.done & (safe_state_sense != safe_state_out);
  assign flt_ev = {mismatch,
    mon_ok & monitor_reference_fail,
    mon_ok & (regulation_reference_uv | monitor_reference_uv),
    mon_ok & overtemp_shutdown, diag_ov, diag_uv};

  // Sticky faults, write one to clear, a new event wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fault <= 14'h0000;
    end else if (wr_en && sel[4]) begin
      fault <= (fault & ~pwdata[13:0]) | flt_ev;
    end else begin
      fault <= fault | flt_ev;
    end
  end

  // Watchdog fault latches until the supply is switched off
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wd_lat <= 1'b0;
    end else if (wd_fault_event) begin
      wd_lat <= 1'b1;
    end else if (!regulators_enable) begin
      wd_lat <= 1'b0;
    end
  end

  // First watchdog fault starts the optional reset pulse
  assign pulse_trig = cfg[`FSS_CFG_PG_WD] & wd_fault_event & ~wd_lat;

  fss_pg_pulse #(
    .CYCLES(PG_PULSE_CYCLES)
  ) u_pg_pulse (
    .pclk(pclk),
    .presetn(presetn),
    .trig(pulse_trig),
    .active(pulse_active)
  );

  // ****************************************
  // Pins
  // ****************************************
  // Open-drain pads only ever pull low
  assign power_good_n_out = 1'b0;
  assign watchdog_fault_n_out = 1'b0;
  assign general_fault_n_out = 1'b0;

  // Power-good held low through startup, then by rail state or the watchdog pulse
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      power_good_n_oe <= 1'b1;
    end else begin
      power_good_n_oe <= ~tif.done | mcu_bad
        | pulse_active
        | (cfg[`FSS_CFG_PG_5V] & g5v_bad);
    end
  end

  // Watchdog and general fault pins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      watchdog_fault_n_oe <= 1'b0;
      general_fault_n_oe <= 1'b0;
    end else begin
      watchdog_fault_n_oe <= wd_lat;
      general_fault_n_oe <= (|fault)
        | (cfg[`FSS_CFG_FF_WD] & wd_lat);
    end
  end

  // Safe state demanded high only when controller is trusted
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      safe_state_out <= 1'b0;
    end else begin
      safe_state_out <= tif.done & ~(wd_lat | mcu_bad);
    end
  end

  // ****************************************
  // Gate drives
  // ****************************************
  assign kill_all = cfg[`FSS_CFG_GATE_WD] & wd_lat;
  assign any_flt = |fault;
  // Battery disconnect always drops on a non-watchdog fault
  assign drive[0] = gate[0] & ~kill_all & ~any_flt;
  genvar gi;
  generate
    for (gi = 1; gi < 4; gi++) begin : g_phase
      // Phases stay up on faults unless the option says otherwise
      assign drive[gi] = gate[gi] & ~kill_all & ~(any_flt & cfg[`FSS_CFG_PHASE_FLT]);
    end
  endgenerate

  // One sources gate current, zero sinks it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      battery_disconnect_drive <= 1'b0;
      phase_a_isolator_drive <= 1'b0;
      phase_b_isolator_drive <= 1'b0;
      phase_c_isolator_drive <= 1'b0;
    end else begin
      battery_disconnect_drive <= drive[0];
      phase_a_isolator_drive <= drive[1];
      phase_b_isolator_drive <= drive[2];
      phase_c_isolator_drive <= drive[3];
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  a_enable_or: assert property (@(posedge pclk) disable iff (!presetn)
    (logic_enable_in | ignition_enable_in) |=> regulators_enable)
    else $error("regulators off with an enable high");
  a_pg_mcu: assert property (@(posedge pclk) disable iff (!presetn)
    mcu_bad |=> power_good_n_oe)
    else $error("power-good not low on mcu rail fault");
  a_pg_pulse: assert property (@(posedge pclk) disable iff (!presetn)
    pulse_trig |-> ##2 power_good_n_oe [*8])
    else $error("power-good pulse missing");
  a_wd_pin: assert property (@(posedge pclk) disable iff (!presetn)
    wd_fault_event |-> ##2 !watchdog_fault_n_oe == 1'b0)
    else $error("watchdog fault pin not low");
  a_gf_fault: assert property (@(posedge pclk) disable iff (!presetn)
    (|flt_ev) |-> ##2 general_fault_n_oe)
    else $error("general fault pin not low on fault");
  a_gf_wd_off: assert property (@(posedge pclk) disable iff (!presetn)
    (wd_lat && !cfg[`FSS_CFG_FF_WD] && fault == 14'h0000) |=> !general_fault_n_oe)
    else $error("watchdog reached general fault by default");
  a_safe_low: assert property (@(posedge pclk) disable iff (!presetn)
    (wd_lat || mcu_bad) |=> !safe_state_out)
    else $error("safe state high during fault");
  a_safe_cmp: assert property (@(posedge pclk) disable iff (!presetn)
    mismatch |=> (fault[`FSS_FLT_MISMATCH] && !status[`FSS_ST_SSOK]))
    else $error("safe state mismatch not flagged");
  a_gate_wd: assert property (@(posedge pclk) disable iff (!presetn)
    kill_all |=> !(battery_disconnect_drive | phase_a_isolator_drive
      | phase_b_isolator_drive | phase_c_isolator_drive))
    else $error("gates on after watchdog fault");
  a_batt_flt: assert property (@(posedge pclk) disable iff (!presetn)
    any_flt |=> !battery_disconnect_drive)
    else $error("battery drive on after fault");
  a_gate_bit: assert property (@(posedge pclk) disable iff (!presetn)
    (!kill_all && !any_flt) |=> (phase_b_isolator_drive == $past(gate[2])))
    else $error("gate bit not applied");
endmodule

// ===== verilog/fss_map.svh
// Register map, field positions, reset values and timing counts.
// Assumes a 25 MHz pclk and a 32-bit APB data path.
`ifndef FSS_MAP_SVH
`define FSS_MAP_SVH
// ****************************************
// Register byte offsets
// ****************************************
`define FSS_STATUS_OFS 8'h00
`define FSS_GATE_OFS 8'h04
`define FSS_CONFIG_OFS 8'h08
`define FSS_VERIFY_OFS 8'h0c
`define FSS_FAULT_OFS 8'h10
// ****************************************
// Fields and reset values
// ****************************************
`define FSS_CFG_GATE_WD 0
`define FSS_CFG_PHASE_FLT 1
`define FSS_CFG_PG_WD 2
`define FSS_CFG_PG_5V 3
`define FSS_CFG_FF_WD 4
`define FSS_CONFIG_RST 5'h00
`define FSS_GATE_RST 4'h0
`define FSS_RAIL_MCU 1
`define FSS_RAIL_G5V 2
`define FSS_FLT_MISMATCH 13
`define FSS_ST_SSOK 0
`define FSS_ST_WDF 1
`define FSS_ST_DONE 2
`define FSS_ST_VFAIL 3
// ****************************************
// Timing
// ****************************************
`define FSS_CLK_NS 40
`define FSS_PG_PULSE_NS 2000000
`define FSS_SETTLE_NS 400
`define FSS_SETTLE_CYC 4'((`FSS_SETTLE_NS + `FSS_CLK_NS - 1) / `FSS_CLK_NS)
`endif

// ===== verilog/fss_pkg.sv
// Types shared by the supervisor and its self-test sequencer.
// Assumes the map header supplies all numbers.
package fss_pkg;
  // One bit per rail: pre-reg, mcu, 5v, sensor 1, sensor 2
  typedef logic [4:0] fss_rail_t;
  // Self-test sequencer states, one-hot
  typedef enum logic [7:0] {
    st_idle = 8'h01, st_uv = 8'h02, st_gap1 = 8'h04, st_ov = 8'h08,
    st_gap2 = 8'h10, st_ot = 8'h20, st_gap3 = 8'h40, st_done = 8'h80
  } fss_test_state_t;
endpackage

// ===== verilog/fss_test_if.sv
// Link between the supervisor core and the self-test sequencer.
// Assumes both ends share pclk.
`timescale 1ns/10ps
interface fss_test_if;
  logic run; // Supply enabled, tests may run
  fss_pkg::fss_rail_t uv_cmp; // Live undervoltage comparators
  fss_pkg::fss_rail_t ov_cmp; // Live overvoltage comparators
  logic ot_cmp; // Live overtemperature comparator
  logic force_uv; // Stimulus enables
  logic force_ov;
  logic force_ot;
  logic [10:0] verify; // Latched failures: ot, ov[4:0], uv[4:0]
  logic testing; // Stimulus window, diagnostics untrusted
  logic done; // Sequence finished, comparators restored
  modport core (output run, uv_cmp, ov_cmp, ot_cmp,
    input force_uv, force_ov, force_ot, verify, testing, done);
  modport tester (input run, uv_cmp, ov_cmp, ot_cmp,
    output force_uv, force_ov, force_ot, verify, testing, done);
endinterface

// ===== verilog/fss_pg_pulse.sv
// Fixed-length low pulse timer for the power-good pin.
// Assumes trig is a single-cycle pulse.
`timescale 1ns/10ps
module fss_pg_pulse #(
  parameter int CYCLES = 50000
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Control
  input wire logic trig,
  output logic active
);
  localparam int W = $clog2(CYCLES + 1);
  logic [W-1:0] cnt; // Cycles left in the pulse
  // Load on trigger, count down to zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= '0;
    end else if (trig) begin
      cnt <= W'(CYCLES);
    end else if (cnt != '0) begin
      cnt <= cnt - 1'b1;
    end
  end
  assign active = (cnt != '0);
endmodule

// ===== verilog/fss_selftest.sv
// Startup comparator self-test sequencer.
// Assumes comparators answer a stimulus within the settle time.
`timescale 1ns/10ps
`include "fss_map.svh"
module fss_selftest (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Core link
  fss_test_if.tester tif
);
  import fss_pkg::*;
  fss_test_state_t state, next_state;
  logic [3:0] cnt; // Cycles spent in a state
  logic [10:0] pre; // Comparator levels before a stimulus
  logic last;
  assign last = (cnt == `FSS_SETTLE_CYC - 4'h1);
  // Sequence: uv, recover, ov, recover, ot, recover, done
  always_comb begin
    next_state = state;
    case (state)
      st_idle: next_state = st_uv;
      st_uv: if (last) next_state = st_gap1;
      st_gap1: if (last) next_state = st_ov;
      st_ov: if (last) next_state = st_gap2;
      st_gap2: if (last) next_state = st_ot;
      st_ot: if (last) next_state = st_gap3;
      st_gap3: if (last) next_state = st_done;
      st_done: next_state = st_done;
      default: next_state = st_idle;
    endcase
    if (!tif.run) begin
      next_state = st_idle;
    end
  end
  // State, counter and pre-stimulus snapshot
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= st_idle;
      cnt <= 4'h0;
      pre <= 11'h000;
    end else begin
      state <= next_state;
      cnt <= (next_state != state) ? 4'h0 : cnt + 4'h1;
      if (next_state != state) begin
        pre <= {tif.ot_cmp, tif.ov_cmp, tif.uv_cmp};
      end
    end
  end
  // Verify bits latch when a bit fails to go 0 to 1
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tif.verify <= 11'h000;
    end else if (state == st_idle) begin
      tif.verify <= 11'h000;
    end else if (last) begin
      if (state == st_uv) tif.verify[4:0] <= tif.verify[4:0] | ~(~pre[4:0] & tif.uv_cmp);
      if (state == st_ov) tif.verify[9:5] <= tif.verify[9:5] | ~(~pre[9:5] & tif.ov_cmp);
      if (state == st_ot) tif.verify[10] <= tif.verify[10] | ~(~pre[10] & tif.ot_cmp);
    end
  end
  // Stimulus drives and phase flags, all registered
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tif.force_uv <= 1'b0;
      tif.force_ov <= 1'b0;
      tif.force_ot <= 1'b0;
      tif.testing <= 1'b0;
      tif.done <= 1'b0;
    end else begin
      tif.force_uv <= (next_state == st_uv);
      tif.force_ov <= (next_state == st_ov);
      tif.force_ot <= (next_state == st_ot);
      tif.testing <= (next_state != st_idle) && (next_state != st_done);
      tif.done <= (next_state == st_done);
    end
  end
  a_uv_verify: assert property (@(posedge pclk) disable iff (!presetn)
    (state == st_uv && last && !tif.uv_cmp[0]) |=> tif.verify[0])
    else $error("uv verify bit not latched");
  a_ot_verify: assert property (@(posedge pclk) disable iff (!presetn)
    (state == st_ot && last && !tif.ot_cmp) |=> tif.verify[10])
    else $error("ot verify bit not latched");
  a_stim_release: assert property (@(posedge pclk) disable iff (!presetn)
    tif.done |-> !(tif.force_uv || tif.force_ov || tif.force_ot))
    else $error("stimulus still applied after tests");
endmodule

// ===== dv/fss_mcu_model.sv
// Far-side model: fault pin pull-ups, comparators and the safe-state pad.
// Assumes the design ties its pin outputs low and only switches the enables.
`timescale 1ns/10ps
module fss_mcu_model (
  // Open-drain enables and resolved pins
  input wire logic pg_oe,
  input wire logic wdf_oe,
  input wire logic gf_oe,
  output logic pg_n,
  output logic wdf_n,
  output logic gf_n,
  // Safe-state pad
  input wire logic safe_out,
  input wire logic break_loop,
  output logic safe_sense,
  // Comparators
  input wire logic uv_force,
  input wire logic ov_force,
  input wire logic ot_force,
  input wire fss_pkg::fss_rail_t live_uv,
  input wire fss_pkg::fss_rail_t live_ov,
  input wire logic live_ot,
  input wire logic [10:0] stuck,
  output fss_pkg::fss_rail_t uv,
  output fss_pkg::fss_rail_t ov,
  output logic ot
);
  import fss_pkg::*;
  // Pull-ups: a pin reads low only while the device sinks it
  assign pg_n = ~pg_oe;
  assign wdf_n = ~wdf_oe;
  assign gf_n = ~gf_oe;
  // Broken pad inverts, so the readback can disagree with the demand
  assign safe_sense = break_loop ? ~safe_out : safe_out;
  // Healthy comparators trip while forced, stuck ones follow only the live level
  assign uv = live_uv | ({5{uv_force}} & ~stuck[4:0]);
  assign ov = live_ov | ({5{ov_force}} & ~stuck[9:5]);
  assign ot = live_ot | (ot_force & ~stuck[10]);
endmodule

// ===== dv/tb_top.sv
// Self-checking bench for the supervisor: APB master, pins and comparators.
// Assumes the far-side model resolves pins and loops the safe-state pad.
`timescale 1ns/10ps
`include "fss_map.svh"
module tb_top;
  import fss_pkg::*;
  localparam int PULSE = 20; // Shortened power-good pulse
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr, regulators_enable, uvf, ovf, otf, safe_out, safe_sense;
  logic logic_enable_in = 0, ignition_enable_in = 0, wd_ev = 0, break_loop = 0;
  logic reg_uv = 0, mon_uv = 0, mon_fail = 0, live_ot = 0, ot;
  fss_rail_t live_uv = 5'h00, live_ov = 5'h00, rail_uv, rail_ov;
  logic [10:0] stuck = 11'h000;
  logic pg_oe, pg_o, wdf_oe, wdf_o, gf_oe, gf_o, pg_n, wdf_n, gf_n;
  logic [3:0] gd; // Battery, phase a, b, c
  int mismatches = 0, tests_run = 0, cyc = 0;
  fss_supervisor #(.PG_PULSE_CYCLES(PULSE)) i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .logic_enable_in(logic_enable_in), .ignition_enable_in(ignition_enable_in),
    .regulators_enable(regulators_enable), .rail_uv(rail_uv), .rail_ov(rail_ov), .overtemp_shutdown(ot),
    .regulation_reference_uv(reg_uv), .monitor_reference_uv(mon_uv), .monitor_reference_fail(mon_fail),
    .wd_fault_event(wd_ev), .uv_test_force(uvf), .ov_test_force(ovf), .ot_test_force(otf),
    .power_good_n_in(pg_n), .power_good_n_out(pg_o), .power_good_n_oe(pg_oe), .watchdog_fault_n_in(wdf_n),
    .watchdog_fault_n_out(wdf_o), .watchdog_fault_n_oe(wdf_oe), .general_fault_n_in(gf_n),
    .general_fault_n_out(gf_o), .general_fault_n_oe(gf_oe), .safe_state_out(safe_out),
    .safe_state_sense(safe_sense), .battery_disconnect_drive(gd[0]), .phase_a_isolator_drive(gd[1]),
    .phase_b_isolator_drive(gd[2]), .phase_c_isolator_drive(gd[3]));
  fss_mcu_model i_mcu (.pg_oe(pg_oe), .wdf_oe(wdf_oe), .gf_oe(gf_oe), .pg_n(pg_n), .wdf_n(wdf_n),
    .gf_n(gf_n), .safe_out(safe_out), .break_loop(break_loop), .safe_sense(safe_sense), .uv_force(uvf),
    .ov_force(ovf), .ot_force(otf), .live_uv(live_uv), .live_ov(live_ov), .live_ot(live_ot),
    .stuck(stuck), .uv(rail_uv), .ov(rail_ov), .ot(ot));
  // ****************************************
  // Clock, reset and hang guard
  // ****************************************
  initial begin
    forever #20 pclk = ~pclk;
  end
  // Ceiling well above the few hundred cycles the scenarios need
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      mismatches++;
      complete_run();
    end
  end
  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask
  // One APB transfer, held until pready is seen high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r,
    output logic e);
    @(posedge pclk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1, a, d, r, e);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] r);
    logic e;
    apb(0, a, 32'h0, r, e);
  endtask
  // Let edges land, then sample mid-cycle
  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
    @(negedge pclk);
  endtask
  task automatic boot(input logic l, input logic i);
    logic [31:0] v = 32'h0;
    @(posedge pclk);
    logic_enable_in <= l;
    ignition_enable_in <= i;
    tick(3);
    chk("regen", 1, regulators_enable);
    chk("pg_hold", 0, pg_n);
    for (int k = 0; k < 60 && v[2] !== 1'b1; k++) rd(`FSS_STATUS_OFS, v);
    chk("done", 1, v[2]);
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_regs();
    logic [31:0] v;
    logic e;
    rd(`FSS_GATE_OFS, v);
    chk("gate_rst", 0, v);
    rd(`FSS_CONFIG_OFS, v);
    chk("cfg_rst", 0, v);
    apb(0, 8'h14, 32'h0, v, e);
    chk("unmapped", 32'h1, {v[30:0], e});
    chk("pin_drive", 0, {pg_o, wdf_o, gf_o});
  endtask
  task automatic t_selftest();
    logic [31:0] v;
    @(posedge pclk) stuck <= 11'h421;
    boot(1, 0);
    rd(`FSS_VERIFY_OFS, v);
    chk("verify_bad", 32'h421, v);
    rd(`FSS_STATUS_OFS, v);
    chk("vfail", 1, v[3]);
    @(posedge pclk);
    logic_enable_in <= 0;
    stuck <= 11'h000;
    tick(3);
    chk("regen_off", 0, regulators_enable);
    boot(0, 1);
    rd(`FSS_VERIFY_OFS, v);
    chk("verify_ok", 0, v);
    rd(`FSS_STATUS_OFS, v);
    chk("status", 9'h1f5, v[8:0]);
    rd(`FSS_FAULT_OFS, v);
    chk("no_false", 0, v);
    chk("pg_up", 1, pg_n);
    chk("safe_up", 1, safe_out);
  endtask
  task automatic t_gates();
    logic [31:0] v;
    for (int i = 0; i < 4; i++) begin
      wr(`FSS_GATE_OFS, 32'(1 << i));
      tick(3);
      chk("gate_one", 32'(1 << i), gd);
    end
    rd(`FSS_GATE_OFS, v);
    chk("gate_rb", 8, v);
    wr(`FSS_GATE_OFS, 32'hf);
  endtask
  task automatic t_rails();
    logic [31:0] v;
    @(posedge pclk) live_uv <= 5'h02;
    tick(3);
    chk("pg_mcu", 0, pg_n);
    chk("safe_mcu", 0, safe_out);
    chk("gf_mcu", 0, gf_n);
    chk("gd_flt", 4'he, gd);
    @(posedge pclk) live_uv <= 5'h00;
    tick(3);
    chk("pg_back", 1, pg_n);
    rd(`FSS_FAULT_OFS, v);
    chk("fault_mcu", 2, v);
    wr(`FSS_FAULT_OFS, 32'h3fff);
    tick(3);
    chk("gf_clr", 1, gf_n);
    @(posedge pclk) live_ov <= 5'h04;
    tick(3);
    chk("pg_5v_def", 1, pg_n);
    wr(`FSS_CONFIG_OFS, 32'h0a);
    tick(3);
    chk("pg_5v_opt", 0, pg_n);
    chk("gd_phase", 0, gd);
    @(posedge pclk) live_ov <= 5'h00;
    tick(3);
    wr(`FSS_FAULT_OFS, 32'h3fff);
    wr(`FSS_CONFIG_OFS, 32'h0);
  endtask
  task automatic t_refs();
    logic [31:0] v;
    @(posedge pclk) mon_fail <= 1;
    tick(3);
    chk("gf_mref", 0, gf_n);
    @(posedge pclk) mon_fail <= 0;
    tick(3);
    rd(`FSS_FAULT_OFS, v);
    chk("fault_mref", 32'h101f, v & 32'h101f);
    wr(`FSS_FAULT_OFS, 32'h3fff);
    for (int i = 0; i < 2; i++) begin
      @(posedge pclk);
      reg_uv <= (i == 0);
      mon_uv <= (i == 1);
      @(posedge pclk);
      reg_uv <= 0;
      mon_uv <= 0;
      tick(3);
      rd(`FSS_FAULT_OFS, v);
      chk("fault_ref", 32'h800, v);
      wr(`FSS_FAULT_OFS, 32'h3fff);
    end
  endtask
  task automatic t_mismatch();
    logic [31:0] v;
    @(posedge pclk) break_loop <= 1;
    tick(3);
    chk("gf_mis", 0, gf_n);
    @(posedge pclk) break_loop <= 0;
    rd(`FSS_STATUS_OFS, v);
    chk("ssok_lo", 0, v[0]);
    rd(`FSS_FAULT_OFS, v);
    chk("fault_mis", 32'h2000, v);
    wr(`FSS_FAULT_OFS, 32'h2000);
    rd(`FSS_STATUS_OFS, v);
    chk("ssok_hi", 1, v[0]);
  endtask
  task automatic t_watchdog();
    int n = 0;
    wr(`FSS_CONFIG_OFS, 32'h05);
    wr(`FSS_GATE_OFS, 32'hf);
    tick(3);
    chk("gd_on", 4'hf, gd);
    @(posedge pclk) wd_ev <= 1;
    @(posedge pclk) wd_ev <= 0;
    for (int k = 0; k < 10 && pg_n !== 1'b0; k++) tick(0);
    while (pg_n === 1'b0 && n < 100) begin
      n++;
      tick(0);
    end
    chk("pg_pulse", PULSE, n);
    chk("wdf_lo", 0, wdf_n);
    chk("safe_wd", 0, safe_out);
    chk("gd_wd", 0, gd);
    chk("gf_wd_def", 1, gf_n);
    tick(10);
    chk("wdf_latch", 0, wdf_n);
    wr(`FSS_CONFIG_OFS, 32'h15);
    @(posedge pclk) wd_ev <= 1;
    @(posedge pclk) wd_ev <= 0;
    tick(4);
    chk("gf_wd_opt", 0, gf_n);
  endtask
  task automatic complete_run();
    if (mismatches == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1;
    t_regs();
    t_selftest();
    t_gates();
    t_rails();
    t_refs();
    t_mismatch();
    t_watchdog();
    complete_run();
  end
endmodule
